// ===== rtl/scsi_xfer_engine.v
// Information transfer command engine of a SCSI protocol controller
// What this block does
// - Receive commands are accepted only while connected as Target.
// - Without single-byte option the byte counter sets the transfer length.
// - Receive clears data-holding-full and drives phase lines in the same cycle.
// - Receive phases: command 010, data 000, msg out 011, info out 001.
// - Counter reaching zero gives done without parity error, service if ATN.
// - Parity error ends Receive; done with parity bit, service if ATN.
// - After Receive interrupt stay Target, REQ and ACK off, counter remains.
// - ATN before a Receive or Send starts: service only, command dropped.
// - Pause stops a transfer only while it waits to raise or see REQ; Disconnect aborts a stalled one.
// - Send is Target-only and clears data-holding-full.
// - Send phases: status 110, data 100, msg in 111, info in 101.
// - Send takes bytes from data register; done, service if ATN.
// - Transfer Info is Initiator-only, once per service interrupt.
// - Initiator raises service on REQ or phase change conditions.
// - Transfer Info clears data-holding-full, direction from stored I/O bit.
// - Count exhausted then REQ or phase change ends with service.
// - Early phase change ends with service, counter keeps remainder.
// - BSY drop during Transfer Info gives disconnected, role left.
// - Last Message In byte: done, ACK held until Message Accepted.
// - Input parity error asserts ATN before ACK release, no interrupt.
// - Device ATN holds until connection end or final message out byte.
// - Chip Reset or Disconnect forces disconnected state.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "scsi_xfer_regs.vh"

module scsi_xfer_engine #(
    parameter CNT_W = 24
) (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire [7:0] sdb_in,
    input wire sdb_par_in,
    output reg [7:0] sdb_out,
    output reg sdb_par_out,
    output reg sdb_oe_out,
    input wire req_in,
    input wire ack_in,
    input wire atn_in,
    input wire bsy_in,
    input wire io_in,
    input wire cd_in,
    input wire msg_in,
    output reg req_out,
    output reg ack_out,
    output reg atn_out,
    output reg io_out,
    output reg cd_out,
    output reg msg_out,
    output reg phase_oe_out,
    output reg dma_req_out
);
    // Engine states
    localparam ST_IDLE = 3'd0;
    localparam ST_T_REQ = 3'd1;
    localparam ST_T_WAIT = 3'd2;
    localparam ST_T_REL = 3'd3;
    localparam ST_I_WAIT = 3'd4;
    localparam ST_I_ACK = 3'd5;
    localparam ST_I_REL = 3'd6;
    localparam ST_I_HOLD = 3'd7;

    reg [2:0] st_r;
    reg [1:0] role_r;
    reg [7:0] cmd_r;
    reg [7:0] ctrl_r;
    reg [CNT_W-1:0] cnt_r;
    reg [7:0] data_r;
    reg dhf_r;
    reg perr_r;
    reg [3:0] int_r;
    reg atn_seen_r;
    reg svc_armed_r;
    reg [2:0] ph_r;
    reg last_r;
    reg dir_in_r;
    reg req_d_r;

    // Odd parity over a data byte
    function par_odd;
        input [7:0] b;
        begin
            par_odd = ~(^b);
        end
    endfunction

    wire [4:0] cmd_op = wdata_in[4:0];
    wire cmd_wr = wr_in && addr_in == `REG_CMD;
    wire single = cmd_r[`CMD_SINGLE_BIT];
    wire cnt_zero = (cnt_r == {CNT_W{1'b0}});
    wire cnt_one = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    wire rx_cmd = cmd_op[4:2] == `CMD_RX_BASE >> 2;
    wire tx_cmd = cmd_op[4:2] == `CMD_TX_BASE >> 2;
    wire data_wr = wr_in && addr_in == `REG_DATA;
    wire data_rd = rd_in && addr_in == `REG_DATA;
    wire [2:0] bus_ph = {io_in, cd_in, msg_in};
    wire par_ok = (par_odd(sdb_in) == sdb_par_in) || !ctrl_r[`CTRL_PAR_EN_BIT];

    // Read data, one cycle after the strobe
    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `REG_CMD: rdata_out <= cmd_r;
                `REG_DATA: rdata_out <= data_r;
                `REG_CTRL: rdata_out <= ctrl_r;
                `REG_CNT0: rdata_out <= cnt_r[7:0];
                `REG_CNT1: rdata_out <= cnt_r[15:8];
                `REG_CNT2: rdata_out <= cnt_r[23:16];
                `REG_AUX: rdata_out <= {dhf_r, perr_r, cnt_zero, 2'b00, ph_r};
                `REG_INT: rdata_out <= {4'h0, int_r};
                `REG_ROLE: rdata_out <= {6'h00, role_r};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // Main sequencer, registers and bus signals
    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_r <= ST_IDLE;
            role_r <= `ROLE_IDLE;
            cmd_r <= 8'h00;
            ctrl_r <= 8'h00;
            cnt_r <= {CNT_W{1'b0}};
            data_r <= 8'h00;
            dhf_r <= 1'b0;
            perr_r <= 1'b0;
            int_r <= 4'h0;
            atn_seen_r <= 1'b0;
            svc_armed_r <= 1'b0;
            ph_r <= 3'd0;
            last_r <= 1'b0;
            dir_in_r <= 1'b0;
            req_d_r <= 1'b0;
            sdb_out <= 8'h00;
            sdb_par_out <= 1'b0;
            sdb_oe_out <= 1'b0;
            req_out <= 1'b0;
            ack_out <= 1'b0;
            atn_out <= 1'b0;
            io_out <= 1'b0;
            cd_out <= 1'b0;
            msg_out <= 1'b0;
            phase_oe_out <= 1'b0;
            dma_req_out <= 1'b0;
        end else begin
            req_d_r <= req_in;
            if (role_r == `ROLE_TARGET && atn_in && st_r != ST_IDLE)
                atn_seen_r <= 1'b1;
            // Register writes; interrupt read clears the register
            if (wr_in && addr_in == `REG_CTRL)
                ctrl_r <= wdata_in;
            if (wr_in && addr_in == `REG_ROLE)
                role_r <= wdata_in[1:0];
            if (wr_in && addr_in == `REG_CNT0)
                cnt_r[7:0] <= wdata_in;
            if (wr_in && addr_in == `REG_CNT1)
                cnt_r[15:8] <= wdata_in;
            if (wr_in && addr_in == `REG_CNT2)
                cnt_r[23:16] <= wdata_in;
            if (data_wr) begin
                data_r <= wdata_in;
                dhf_r <= 1'b1;
            end
            if (data_rd)
                dhf_r <= 1'b0;
            if (rd_in && addr_in == `REG_INT)
                int_r <= 4'h0;
            if (role_r == `ROLE_INIT && st_r == ST_IDLE && !svc_armed_r &&
                    ((req_in && !req_d_r) || bus_ph != ph_r)) begin
                int_r[`INT_SERVICE_BIT] <= 1'b1;
                svc_armed_r <= 1'b1;
                ph_r <= bus_ph;
            end
            dma_req_out <= 1'b0;
            if (cmd_wr) begin
                cmd_r <= wdata_in;
                case (cmd_op)
                    `CMD_DISCONNECT, `CMD_CHIP_RESET: begin
                        st_r <= ST_IDLE;
                        role_r <= `ROLE_IDLE;
                        req_out <= 1'b0;
                        ack_out <= 1'b0;
                        atn_out <= 1'b0;
                        sdb_oe_out <= 1'b0;
                        phase_oe_out <= 1'b0;
                    end
                    `CMD_PAUSE: begin
                        if (st_r == ST_T_REQ || st_r == ST_I_WAIT) begin
                            st_r <= ST_IDLE;
                            req_out <= 1'b0;
                            sdb_oe_out <= 1'b0;
                        end
                    end
                    `CMD_SET_ATN: begin
                        if (role_r == `ROLE_INIT)
                            atn_out <= 1'b1;
                    end
                    `CMD_MSG_ACCEPTED: begin
                        if (st_r == ST_I_HOLD) begin
                            ack_out <= 1'b0;
                            st_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        if ((rx_cmd || tx_cmd) && role_r == `ROLE_TARGET && st_r == ST_IDLE)
                            begin
                            dhf_r <= 1'b0;
                            perr_r <= 1'b0;
                            if (atn_in) begin
                                int_r[`INT_SERVICE_BIT] <= 1'b1;
                            end else begin
                                io_out <= tx_cmd;
                                cd_out <= ~cmd_op[1];
                                msg_out <= cmd_op[0];
                                phase_oe_out <= 1'b1;
                                atn_seen_r <= 1'b0;
                                last_r <= wdata_in[`CMD_SINGLE_BIT];
                                st_r <= ST_T_REQ;
                            end
                        end else if ((cmd_op == `CMD_XFER_INFO || cmd_op == `CMD_XFER_PAD) &&
                                role_r == `ROLE_INIT && svc_armed_r && st_r == ST_IDLE) begin
                            // one per service; clear and direction
                            svc_armed_r <= 1'b0;
                            dhf_r <= 1'b0;
                            perr_r <= 1'b0;
                            dir_in_r <= ph_r[2];
                            last_r <= 1'b0;
                            st_r <= ST_I_WAIT;
                        end else if (cmd_op != `CMD_NOP) begin
                            int_r[`INT_INVALID_BIT] <= 1'b1;
                        end
                    end
                endcase
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        sdb_oe_out <= 1'b0;
                    end
                    // Target: wait for data (Send) or an empty data register (Receive), then assert REQ
                    ST_T_REQ: begin
                        dma_req_out <= cmd_r[`CMD_DMA_BIT] && io_out && !dhf_r;
                        if (!io_out && !dhf_r) begin
                            req_out <= 1'b1;
                            st_r <= ST_T_WAIT;
                        end else if (io_out && dhf_r) begin
                            sdb_out <= data_r;
                            sdb_par_out <= par_odd(data_r);
                            sdb_oe_out <= 1'b1;
                            dhf_r <= data_wr;
                            req_out <= 1'b1;
                            st_r <= ST_T_WAIT;
                        end
                    end
                    ST_T_WAIT: begin
                        if (ack_in) begin
                            req_out <= 1'b0;
                            if (!io_out) begin
                                data_r <= sdb_in;
                                dhf_r <= 1'b1;
                                dma_req_out <= cmd_r[`CMD_DMA_BIT];
                                if (!par_ok)
                                    perr_r <= 1'b1;
                            end
                            if (!single)
                                cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
                            st_r <= ST_T_REL;
                        end
                    end
                    // end with REQ and ACK off
                    ST_T_REL: begin
                        if (!ack_in && (io_out || !dhf_r)) begin // Last byte read first
                            sdb_oe_out <= 1'b0;
                            if (single || cnt_zero || perr_r) begin
                                int_r[`INT_DONE_BIT] <= 1'b1;
                                int_r[`INT_SERVICE_BIT] <= atn_seen_r || atn_in;
                                st_r <= ST_IDLE;
                            end else begin
                                st_r <= ST_T_REQ;
                            end
                        end
                    end
                    // Initiator: wait for REQ, watch phase and BSY
                    ST_I_WAIT: begin
                        dma_req_out <= cmd_r[`CMD_DMA_BIT] && !dir_in_r && !dhf_r;
                        if (!bsy_in) begin
                            int_r[`INT_DISC_BIT] <= 1'b1;
                            role_r <= `ROLE_IDLE;
                            atn_out <= 1'b0;
                            st_r <= ST_IDLE;
                        end else if (bus_ph != ph_r || (req_in && (last_r || cnt_zero))) begin
                            int_r[`INT_SERVICE_BIT] <= 1'b1;
                            svc_armed_r <= 1'b1;
                            ph_r <= bus_ph;
                            st_r <= ST_IDLE;
                        end else if (req_in && (dir_in_r || dhf_r)) begin
                            if (dir_in_r) begin
                                data_r <= sdb_in;
                                dhf_r <= 1'b1;
                                if (!par_ok) begin
                                    perr_r <= 1'b1;
                                    atn_out <= 1'b1;
                                end
                            end else begin
                                sdb_out <= data_r;
                                sdb_par_out <= par_odd(data_r);
                                sdb_oe_out <= 1'b1;
                                dhf_r <= data_wr;
                                // drop ATN before final message byte
                                if (ph_r[1:0] == 2'b11 && (single || cnt_one))
                                    atn_out <= 1'b0;
                            end
                            st_r <= ST_I_ACK;
                        end
                    end
                    ST_I_ACK: begin
                        ack_out <= 1'b1;
                        if (!single)
                            cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
                        last_r <= single;
                        st_r <= ST_I_REL;
                    end
                    // last message in byte keeps ACK
                    ST_I_REL: begin
                        if (ph_r == 3'b111 && (single || cnt_zero)) begin
                            int_r[`INT_DONE_BIT] <= 1'b1;
                            st_r <= ST_I_HOLD;
                        end else if (!req_in) begin
                            ack_out <= 1'b0;
                            sdb_oe_out <= 1'b0;
                            st_r <= ST_I_WAIT;
                        end
                    end
                    ST_I_HOLD: begin
                        sdb_oe_out <= 1'b0;
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // scsi_xfer_engine

// ===== rtl/scsi_xfer_regs.vh
// Constants for the information transfer command engine
`ifndef SCSI_XFER_REGS_VH
`define SCSI_XFER_REGS_VH
// Register offsets
`define REG_CMD 4'h0
`define REG_DATA 4'h1
`define REG_CTRL 4'h2
`define REG_CNT0 4'h3
`define REG_CNT1 4'h4
`define REG_CNT2 4'h5
`define REG_AUX 4'h6
`define REG_INT 4'h7
`define REG_ROLE 4'h8
// Command codes (bits 4:0 of the command register)
`define CMD_NOP 5'h00
`define CMD_DISCONNECT 5'h04
`define CMD_PAUSE 5'h05
`define CMD_SET_ATN 5'h06
`define CMD_MSG_ACCEPTED 5'h07
`define CMD_CHIP_RESET 5'h01
`define CMD_RX_BASE 5'h08
`define CMD_TX_BASE 5'h0c
`define CMD_XFER_INFO 5'h14
`define CMD_XFER_PAD 5'h15
// Command register fields
`define CMD_SINGLE_BIT 7
`define CMD_DMA_BIT 6
// Control register fields
`define CTRL_PAR_EN_BIT 0
// Interrupt register bits
`define INT_DONE_BIT 0
`define INT_SERVICE_BIT 1
`define INT_DISC_BIT 2
`define INT_INVALID_BIT 3
// Auxiliary status bits
`define AUX_DHF_BIT 7
`define AUX_PERR_BIT 6
`define AUX_ZERO_BIT 5
// Roles
`define ROLE_IDLE 2'h0
`define ROLE_TARGET 2'h1
`define ROLE_INIT 2'h2
`endif

// ===== tb/scsi_xfer_engine_asserts.sv
// Port-level assertions for the information transfer command engine
`timescale 1ns/1ps
`include "scsi_xfer_regs.vh"

module scsi_xfer_engine_asserts (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire ack_in,
    input wire atn_in,
    input wire [7:0] sdb_out,
    input wire sdb_par_out,
    input wire sdb_oe_out,
    input wire req_out,
    input wire ack_out,
    input wire io_out,
    input wire cd_out,
    input wire msg_out,
    input wire phase_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    reg tgt_r;
    wire cmd_w = wr_in && addr_in == `REG_CMD;
    wire rx_w = cmd_w && wdata_in[4:2] == 3'b010 && tgt_r && !atn_in;
    wire tx_w = cmd_w && wdata_in[4:2] == 3'b011 && tgt_r && !atn_in;
    // Tracks whether software has put the block in the Target role
    always @(posedge sys_clk_in) begin
        if (!nrst_in) tgt_r <= 1'b0;
        else if (wr_in && addr_in == `REG_ROLE) tgt_r <= wdata_in[1:0] == `ROLE_TARGET;
        else if (cmd_w && (wdata_in[4:0] == `CMD_DISCONNECT ||
                 wdata_in[4:0] == `CMD_CHIP_RESET)) tgt_r <= 1'b0;
    end
    a_rx_phase: assert property (rx_w |=> phase_oe_out && !io_out &&
        cd_out == !$past(wdata_in[1]) && msg_out == $past(wdata_in[0]))
        else $error("Receive phase lines wrong");
    a_tx_phase: assert property (tx_w |=> phase_oe_out && io_out &&
        cd_out == !$past(wdata_in[1]) && msg_out == $past(wdata_in[0]))
        else $error("Send phase lines wrong");
    a_no_target: assert property (
        cmd_w && wdata_in[4:3] == 2'b01 && !tgt_r |=> !phase_oe_out [*3])
        else $error("Transfer started without Target role");
    a_odd_parity: assert property (sdb_oe_out |-> ^{sdb_out, sdb_par_out})
        else $error("Driven byte has even parity");
    a_req_phase: assert property (req_out |-> phase_oe_out)
        else $error("REQ without phase lines");
    a_req_drop: assert property (req_out && ack_in |-> ##[1:3] !req_out)
        else $error("REQ not released after ACK");
    a_req_ack: assert property (req_out |-> !ack_out)
        else $error("REQ and ACK driven together");
    a_disc_idle: assert property (
        cmd_w && wdata_in[4:0] == `CMD_DISCONNECT |-> ##[1:4]
        (!phase_oe_out && !req_out && !ack_out))
        else $error("Disconnect left bus driven");
    c_rx: cover property (rx_w);
    c_tx: cover property (tx_w);
    c_hs: cover property (req_out && ack_in);
endmodule // scsi_xfer_engine_asserts

bind scsi_xfer_engine scsi_xfer_engine_asserts u_chk (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .ack_in(ack_in), .atn_in(atn_in),
    .sdb_out(sdb_out), .sdb_par_out(sdb_par_out), .sdb_oe_out(sdb_oe_out),
    .req_out(req_out), .ack_out(ack_out), .io_out(io_out), .cd_out(cd_out),
    .msg_out(msg_out), .phase_oe_out(phase_oe_out)
);

// ===== tb/scsi_ini_model.sv
// Behavioural SCSI initiator answering the target's REQ/ACK handshakes
`timescale 1ns/1ps

module scsi_ini_model (
    input wire clk_in,
    input wire req_in,
    input wire io_in,
    input wire [7:0] sdb_in,
    input wire [3:0] dly_in,
    input wire [3:0] bad_in,
    output reg ack_out,
    output reg [7:0] sdb_out,
    output reg par_out
);
    reg [7:0] src_q[$];
    reg [7:0] got_q[$];
    reg [7:0] b;
    integer n = 0;
    integer k;
    // Sample just after the edge so the engine's updates have landed
    task tick;
        @(posedge clk_in);
        #1;
    endtask
    // One byte per REQ: data first, ACK held until REQ drops
    initial begin
        ack_out = 1'b0;
        sdb_out = 8'h00;
        par_out = 1'b1;
        forever begin
            tick;
            if (req_in) begin
                repeat (dly_in) tick;
                if (io_in) got_q.push_back(sdb_in);
                else begin
                    b = src_q.size() > 0 ? src_q.pop_front() : 8'h3c;
                    sdb_out = b;
                    // Odd parity, spoilt on the chosen byte only
                    par_out = ~^b ^ (n == bad_in);
                    n = n + 1;
                    tick;
                end
                ack_out = 1'b1;
                for (k = 0; k < 64 && req_in; k = k + 1) tick;
                ack_out = 1'b0;
                // Released lines must not keep the old byte
                sdb_out = ~sdb_out;
                par_out = ~par_out;
            end
        end
    end
endmodule // scsi_ini_model

// ===== tb/scsi_xfer_engine_tb.sv
// Self-checking bench for the transfer command engine in both roles
`timescale 1ns/1ps
`include "scsi_xfer_regs.vh"

module scsi_xfer_engine_tb;
    reg sys_clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg [3:0] addr_in = 4'h0;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg atn_in = 1'b0;
    reg [3:0] dly = 4'h0;
    reg [3:0] bad = 4'hf;
    reg ini_bsy = 1'b1;
    reg [2:0] ini_ph = 3'h0;
    reg [31:0] seed = 32'hbb0d;
    reg [7:0] exp_q[$];
    reg [7:0] d;
    integer err_total = 0;
    integer comparisons = 0;
    integer i;
    wire [7:0] rdata_out, dut_sdb, ini_sdb, sdb_w;
    wire dut_par, ini_par, par_w, dut_oe, req_w, ack_w, io_w;
    // Shared data lines: whoever enables drives them
    assign sdb_w = dut_oe ? dut_sdb : ini_sdb;
    assign par_w = dut_oe ? dut_par : ini_par;
    always #25 sys_clk_in = ~sys_clk_in;

    scsi_xfer_engine u_scsi_xfer_engine (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .sdb_in(sdb_w), .sdb_par_in(par_w), .sdb_out(dut_sdb), .sdb_par_out(dut_par),
        .sdb_oe_out(dut_oe), .req_in(1'b0), .ack_in(ack_w), .atn_in(atn_in),
        .bsy_in(ini_bsy), .io_in(ini_ph[2]), .cd_in(ini_ph[1]), .msg_in(ini_ph[0]),
        .req_out(req_w),
        .ack_out(), .atn_out(), .io_out(io_w), .cd_out(), .msg_out(),
        .phase_oe_out(), .dma_req_out()
    );
    scsi_ini_model u_ini (
        .clk_in(sys_clk_in), .req_in(req_w), .io_in(io_w), .sdb_in(sdb_w),
        .dly_in(dly), .bad_in(bad), .ack_out(ack_w), .sdb_out(ini_sdb), .par_out(ini_par)
    );

    task chk(input string nm, input [7:0] e, input [7:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("Checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Xorshift step for repeatable random values
    function [31:0] xorshift(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xorshift = x ^ (x << 5);
        end
    endfunction
    task wr(input [3:0] a, input [7:0] v);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task rd(input [3:0] a, output [7:0] v);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
        @(posedge sys_clk_in);
    endtask
    // Interrupt code: 0 done, 1 done and service, 2 service only, 3 invalid
    function [7:0] exp_int(input [1:0] m);
        exp_int = (m == 2'h3) ? 8'h08 : {6'h00, m != 2'h0, m != 2'h2};
    endfunction
    // One Receive or Send; bi is the spoilt byte, atn_at the poll step raising ATN
    task run(input [7:0] op, input integer nb, input [3:0] bi, input integer atn_at,
             input [1:0] m);
        reg [7:0] v;
        integer t, k, mv, g, j;
        exp_q.delete();
        for (j = 0; j < nb; j = j + 1) begin
            seed = xorshift(seed);
            exp_q.push_back(seed[7:0]);
            if (!op[2]) u_ini.src_q.push_back(seed[7:0]);
        end
        u_ini.n = 0;
        bad <= bi;
        dly <= {2'h0, seed[9:8]};
        mv = (m == 2'h2) ? 0 : (bi < nb ? bi + 1 : nb);
        wr(`REG_CNT0, nb[7:0] + (op[7] ? 8'h02 : 8'h00));
        wr(`REG_CNT1, 8'h00);
        wr(`REG_CNT2, 8'h00);
        wr(`REG_CMD, op);
        v = 8'h00;
        k = 0;
        for (t = 0; t < 300 && v === 8'h00; t = t + 1) begin
            if (t == atn_at) atn_in <= 1'b1;
            rd(`REG_AUX, d);
            if (op[2] && !d[`AUX_DHF_BIT] && k < nb) begin
                wr(`REG_DATA, exp_q[k]);
                k = k + 1;
            end else if (!op[2] && d[`AUX_DHF_BIT]) begin
                rd(`REG_DATA, d);
                chk("rx byte", exp_q[k], d);
                k = k + 1;
            end
            rd(`REG_INT, v);
        end
        if (v === 8'h00) begin
            err_total = err_total + 1;
            $display("[FAIL] interrupt expected set seen 00");
            test_done;
        end
        atn_in <= 1'b0;
        chk("int", exp_int(m), v);
        g = op[2] ? u_ini.got_q.size() : k;
        chk("moved", mv[7:0], g[7:0]);
        for (j = 0; j < u_ini.got_q.size(); j = j + 1) begin
            chk("tx byte", exp_q[j], u_ini.got_q[j]);
        end
        if (!op[7]) begin
            rd(`REG_CNT0, d);
            chk("count left", nb[7:0] - mv[7:0], d);
        end
        rd(`REG_AUX, d);
        chk("parity flag", (!op[2] && bi < nb) ? 8'h40 : 8'h00, d & 8'h40);
        u_ini.src_q.delete();
        u_ini.got_q.delete();
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        // Transfer commands while not connected are refused
        for (i = 0; i < 8; i = i + 1) begin
            wr(`REG_CMD, 8'h08 + i[7:0]);
            rd(`REG_INT, d);
            chk("not target", exp_int(2'h3), d);
        end
        wr(`REG_ROLE, 8'h01);
        wr(`REG_CTRL, 8'h01);
        // Every Receive and Send phase with a random length
        for (i = 0; i < 8; i = i + 1) begin
            seed = xorshift(seed);
            run(8'h08 + i[7:0], 1 + seed[1:0], 4'hf, 999, 2'h0);
        end
        run(8'h09, 4, 4'h1, 999, 2'h0);
        run(8'h0a, 4, 4'h0, 999, 2'h0);
        run(8'h0b, 4, 4'hf, 1, 2'h1);
        run(8'h0d, 4, 4'hf, 1, 2'h1);
        run(8'h88, 1, 4'hf, 999, 2'h0);
        run(8'h8e, 1, 4'hf, 999, 2'h0);
        // ATN already up when the command arrives
        atn_in <= 1'b1;
        @(posedge sys_clk_in);
        run(8'h09, 2, 4'hf, 999, 2'h2);
        wr(`REG_CMD, {3'h0, `CMD_DISCONNECT});
        rd(`REG_ROLE, d);
        chk("role", 8'h00, d);
        // Initiator: one Transfer Info per service, BSY loss disconnects
        wr(`REG_ROLE, 8'h02);
        wr(`REG_CMD, {3'h0, `CMD_XFER_INFO});
        rd(`REG_INT, d);
        chk("info unarmed", exp_int(2'h3), d);
        ini_ph <= 3'h2;
        @(posedge sys_clk_in);
        rd(`REG_INT, d);
        chk("phase service", exp_int(2'h2), d);
        wr(`REG_CMD, {3'h4, `CMD_XFER_INFO});
        wr(`REG_CMD, {3'h0, `CMD_XFER_INFO});
        rd(`REG_INT, d);
        chk("second info", exp_int(2'h3), d);
        ini_bsy <= 1'b0;
        @(posedge sys_clk_in);
        rd(`REG_INT, d);
        chk("bsy lost", 8'h04, d);
        rd(`REG_ROLE, d);
        chk("role left", 8'h00, d);
        test_done;
    end
endmodule // scsi_xfer_engine_tb
